// file: logic/supervisor_pkg.sv
// supervisor_pkg: timing, input layout and widths of the supply supervisor
// assumes a single 40 MHz clock feeds every user of these constants
`default_nettype none
package supervisor_pkg;

  // ----------------------------------------------------------------------
  // clock and documented times
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned RESET_HOLD_MS = 150;
  localparam int unsigned WATCHDOG_TIMEOUT_MS = 1650;
  localparam int unsigned CE_GRACE_US = 12;
  localparam int unsigned ACT_MIN_PULSE_NS = 100;

  // ----------------------------------------------------------------------
  // derived cycle counts
  // ----------------------------------------------------------------------
  localparam int unsigned RESET_HOLD_CYCLES = RESET_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned WATCHDOG_TIMEOUT_CYCLES =
    WATCHDOG_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned CE_GRACE_CYCLES = CE_GRACE_US * (CLK_HZ / 1000000);
  // shortest activity pulse, rounded up; two sync stages need at least one
  localparam int unsigned ACT_MIN_PULSE_CYCLES =
    (ACT_MIN_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // ----------------------------------------------------------------------
  // counter widths and loads
  // ----------------------------------------------------------------------
  localparam int unsigned HOLD_W = 24;
  localparam int unsigned WD_W = 28;
  localparam int unsigned GRACE_W = 9;
  localparam logic [GRACE_W-1:0] CE_GRACE_LOAD = 9'h1DF;

  // ----------------------------------------------------------------------
  // synchronised input vector layout
  // ----------------------------------------------------------------------
  localparam int unsigned IN_W = 8;
  localparam int unsigned IN_SUPPLY_LOW = 0;
  localparam int unsigned IN_MANUAL_N = 1;
  localparam int unsigned IN_AUX_N = 2;
  localparam int unsigned IN_ACTIVITY = 3;
  localparam int unsigned IN_WD_CONN = 4;
  localparam int unsigned IN_BACKUP_ABOVE = 5;
  localparam int unsigned IN_SUPPLY_ABOVE = 6;
  localparam int unsigned IN_CE_N = 7;
  // supply low, manual and aux inactive high, chip enable idle high
  localparam logic [IN_W-1:0] SYNC_RESET = 8'h87;

endpackage
`default_nettype wire

// file: logic/watchdog_if.sv
// watchdog_if: links the supervisor core to its watchdog timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface watchdog_if;
  logic activity;
  logic enable;
  logic clear;
  logic expire;
  modport timer (input activity, input enable, input clear, output expire);
  modport core (output activity, output enable, output clear, input expire);
endinterface
`default_nettype wire

// file: logic/watchdog_timer.sv
// watchdog_timer: counts idle time of the synchronised activity line
// assumes activity already passed two flip-flops in the caller
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer
  import supervisor_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = WATCHDOG_TIMEOUT_CYCLES
) (
  input wire logic clk, // 40 MHz clock
  input wire logic rst_n, // async reset, active low
  watchdog_if.timer wd // activity in, expiry out
);

  typedef struct packed {
    logic prev;
    logic [WD_W-1:0] count;
    logic expire;
  } wd_state_t;

  wd_state_t st;
  wd_state_t next_st;
  logic edgeSeen;

  assign edgeSeen = wd.activity != st.prev;
  assign wd.expire = st.expire;

  // --------------------------------------------------------------------
  // idle counter
  // --------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.prev = wd.activity;
    next_st.expire = 1'b0;
    if (wd.clear || !wd.enable || edgeSeen) begin
      next_st.count = '0;
    end else if (st.count == WD_W'(TIMEOUT_CYCLES - 1)) begin
      next_st.count = '0;
      next_st.expire = 1'b1;
    end else begin
      next_st.count = st.count + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_edge_clears_count: assert property (
    edgeSeen |=> st.count == '0 && !st.expire)
    else $error("activity edge did not clear watchdog");
  chk_clear_on_reset: assert property (
    wd.clear |=> st.count == '0 && !st.expire)
    else $error("reset did not clear watchdog");
  chk_expire_at_limit: assert property (
    st.expire |-> $past(st.count) == WD_W'(TIMEOUT_CYCLES - 1))
    else $error("watchdog expired at wrong count");
  chk_disabled_silent: assert property (
    !wd.enable |=> !st.expire)
    else $error("disabled watchdog expired");
  cov_expire: cover property (st.expire);
endmodule
`default_nettype wire

// file: logic/supply_supervisor_reset_gating.sv
// supply_supervisor_reset_gating: reset, watchdog, backup flag and CE gating
// assumes comparator results arrive as asynchronous digital levels
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_reset_gating
  import supervisor_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = RESET_HOLD_CYCLES,
  parameter int unsigned WD_CYCLES = WATCHDOG_TIMEOUT_CYCLES
) (
  input wire logic clk, // 40 MHz internal oscillator
  input wire logic rst_n, // async reset, active low
  input wire logic supplyLow, // main supply below threshold
  input wire logic manualResetN, // manual reset, active low
  input wire logic auxUndervoltageN, // aux input, low when under reference
  input wire logic watchdogActivityIn, // processor activity line
  input wire logic watchdogConnected, // activity line is driven
  input wire logic backupAbove, // battery exceeds supply by margin
  input wire logic supplyAbove, // supply exceeds battery by margin
  input wire logic chipEnableInN, // chip enable from processor
  output logic resetN, // push-pull reset, active low
  output logic resetOdOut, // open-drain data value, always low
  output logic resetLowOdOeN, // active-low open-drain enable
  output logic resetHighOdOeN, // active-high open-drain enable
  output logic backupActive, // battery backup mode
  output logic outputFromBackup, // switched output on battery
  output logic chipEnableOutN // gated chip enable to memory
);
  import supervisor_pkg::*;

  typedef struct packed {
    logic [IN_W-1:0] syncA;
    logic [IN_W-1:0] syncB;
    logic [HOLD_W-1:0] holdCnt;
    logic resetOn;
    logic backup;
    logic fromBackup;
    logic grace;
    logic [GRACE_W-1:0] graceCnt;
    logic ceOutN;
  } state_t;

  state_t st;
  state_t next_st;
  logic [IN_W-1:0] pins;
  logic cause;
  logic ceIn;
  watchdog_if wd ();

  assign pins = {chipEnableInN, supplyAbove, backupAbove, watchdogConnected,
                 watchdogActivityIn, auxUndervoltageN, manualResetN,
                 supplyLow};
  // ----------------------------------------------------------------------
  // reset causes from synchronised levels
  // ----------------------------------------------------------------------
  assign cause = st.syncB[IN_SUPPLY_LOW] | ~st.syncB[IN_MANUAL_N] |
                 ~st.syncB[IN_AUX_N];
  assign ceIn = st.syncB[IN_CE_N];

  assign wd.activity = st.syncB[IN_ACTIVITY];
  assign wd.enable = st.syncB[IN_WD_CONN];
  assign wd.clear = st.resetOn;

  watchdog_timer #(.TIMEOUT_CYCLES(WD_CYCLES)) u_watchdog (
    .clk(clk),
    .rst_n(rst_n),
    .wd(wd.timer)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.syncA = pins;
    next_st.syncB = st.syncA;
    if (cause) begin
      next_st.holdCnt = HOLD_W'(HOLD_CYCLES);
    end else if (wd.expire) begin
      next_st.holdCnt = HOLD_W'(HOLD_CYCLES);
    end else if (st.holdCnt != '0) begin
      next_st.holdCnt = st.holdCnt - 1'b1;
    end
    next_st.resetOn = next_st.holdCnt != '0;

    if (st.syncB[IN_SUPPLY_LOW] && st.syncB[IN_BACKUP_ABOVE]) begin
      next_st.backup = 1'b1;
    end else if (!st.syncB[IN_SUPPLY_LOW] || st.syncB[IN_SUPPLY_ABOVE]) begin
      next_st.backup = 1'b0;
    end
    next_st.fromBackup = next_st.resetOn & next_st.backup;

    if (next_st.resetOn && !st.resetOn) begin
      next_st.grace = ~ceIn;
      next_st.graceCnt = CE_GRACE_LOAD;
    end else if (!next_st.resetOn) begin
      next_st.grace = 1'b0;
    end else if (st.grace && (ceIn || st.graceCnt == '0)) begin
      next_st.grace = 1'b0;
    end else if (st.grace) begin
      next_st.graceCnt = st.graceCnt - 1'b1;
    end
    if (next_st.resetOn) begin
      next_st.ceOutN = ~next_st.grace | ceIn;
    end else begin
      next_st.ceOutN = ceIn;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st.syncA <= SYNC_RESET;
      st.syncB <= SYNC_RESET;
      st.holdCnt <= '0;
      st.resetOn <= 1'b1;
      st.backup <= 1'b0;
      st.fromBackup <= 1'b0;
      st.grace <= 1'b0;
      st.graceCnt <= '0;
      st.ceOutN <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign resetN = ~st.resetOn;
  assign resetOdOut = 1'b0;
  assign resetLowOdOeN = ~st.resetOn;
  assign resetHighOdOeN = st.resetOn;
  assign backupActive = st.backup;
  assign outputFromBackup = st.fromBackup;
  assign chipEnableOutN = st.ceOutN;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_cause_holds_reset: assert property (
    cause |=> st.resetOn && st.holdCnt == HOLD_W'(HOLD_CYCLES))
    else $error("reset not held during cause");
  chk_release_after_hold: assert property (
    $fell(st.resetOn) |-> $past(st.holdCnt) == 1 && !$past(cause))
    else $error("reset released before hold time");
  chk_hold_counts_down: assert property (
    !cause && !wd.expire && st.holdCnt != '0 |=>
      st.holdCnt == $past(st.holdCnt) - 1'b1)
    else $error("hold counter not decrementing");
  chk_watchdog_pulse: assert property (
    wd.expire && !cause |=> st.resetOn && st.holdCnt == HOLD_W'(HOLD_CYCLES))
    else $error("watchdog expiry gave no reset pulse");
  chk_variants_agree: assert property (
    resetN == resetLowOdOeN && resetN != resetHighOdOeN)
    else $error("reset variants disagree");
  chk_ce_pass_normal: assert property (
    !st.resetOn ##1 !st.resetOn |-> chipEnableOutN == $past(ceIn))
    else $error("chip enable not passed outside reset");
  chk_ce_blocked: assert property (
    st.resetOn && !st.grace |-> chipEnableOutN)
    else $error("chip enable low during reset after grace");
  chk_grace_start: assert property (
    !st.resetOn ##1 st.resetOn && !$past(ceIn) |->
      st.grace && st.graceCnt == CE_GRACE_LOAD)
    else $error("grace not started with chip enable low");
  chk_backup_entry: assert property (
    st.syncB[IN_SUPPLY_LOW] && st.syncB[IN_BACKUP_ABOVE] |=> backupActive)
    else $error("backup mode not entered");
  chk_output_select: assert property (
    outputFromBackup |-> st.resetOn && backupActive)
    else $error("switched output on battery outside reset");
  // properties read the synchronised levels, two edges behind the pins
  chk_manual_cause: assert property (
    !st.syncB[IN_MANUAL_N] |=> st.resetOn)
    else $error("manual reset low did not assert reset");
  chk_aux_cause: assert property (
    !st.syncB[IN_AUX_N] |=> st.resetOn)
    else $error("aux undervoltage did not assert reset");
  chk_hold_loaded: assert property (
    $fell(cause) |-> st.holdCnt == HOLD_W'(HOLD_CYCLES))
    else $error("hold time not full when cause cleared");
  chk_backup_exit: assert property (
    !st.syncB[IN_SUPPLY_LOW] ||
      (st.syncB[IN_SUPPLY_ABOVE] && !st.syncB[IN_BACKUP_ABOVE]) |=>
      !backupActive)
    else $error("backup mode not left");
  chk_grace_keeps_low: assert property (
    st.grace |-> !chipEnableOutN)
    else $error("chip enable high during grace");
  chk_grace_end: assert property (
    st.grace && (ceIn || st.graceCnt == '0) |=> !st.grace)
    else $error("grace not ended on input high or limit");
  chk_ce_high_start: assert property (
    !st.resetOn ##1 st.resetOn && $past(ceIn) |->
      chipEnableOutN && !st.grace)
    else $error("chip enable low after reset began with input high");

  cov_manual_reset: cover property (!st.syncB[IN_MANUAL_N] ##1 st.resetOn);
  cov_grace_used: cover property (st.grace ##1 !st.grace && st.resetOn);
  cov_backup_mode: cover property ($rose(backupActive));
  cov_watchdog_reset: cover property (wd.expire ##1 st.resetOn);
endmodule
`default_nettype wire

// file: testbench/processor_model.sv
// processor_model: processor and memory master facing the supervisor
// assumes the bench clock; drives activity on the falling edge, chip enable straight from ceLowReq
`timescale 1ns/1ps
`default_nettype none
module processor_model #(
  parameter int KICK_CYCLES = 10
) (
  input wire logic clk, // system clock
  input wire logic kickOn, // keep servicing the watchdog
  input wire logic ceLowReq, // memory access wanted
  output logic watchdogActivityIn, // activity line
  output logic chipEnableInN // chip enable into the gate
);
  int kickCnt = 0;

  initial watchdogActivityIn = 1'h0;

  // ----------------------------------------------------------------------
  // activity toggling, wide pulses well inside the timeout
  // ----------------------------------------------------------------------
  always @(negedge clk) begin
    if (kickOn && kickCnt >= KICK_CYCLES - 1) begin
      watchdogActivityIn <= ~watchdogActivityIn;
      kickCnt <= 0;
    end else begin
      kickCnt <= kickCnt + 1;
    end
  end

  assign chipEnableInN = ~ceLowReq;
endmodule
`default_nettype wire

// file: testbench/supply_supervisor_reset_gating_tb_top.sv
// supply_supervisor_reset_gating_tb_top: self-checking bench
// assumes short hold and watchdog counts; the processor model drives lines
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_reset_gating_tb_top;
  import supervisor_pkg::*;
  localparam int HOLD = 20;
  localparam int WDC = 50;
  localparam int GRACE = CE_GRACE_CYCLES;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic supplyLow = 1'h0;
  logic manualResetN = 1'h1;
  logic auxUndervoltageN = 1'h1;
  logic watchdogConnected = 1'h0;
  logic backupAbove = 1'h0;
  logic supplyAbove = 1'h0;
  logic kickOn = 1'h0;
  logic ceLowReq = 1'h0;
  wire logic activity;
  wire logic ceInN;
  logic resetN, resetOdOut, resetLowOdOeN, resetHighOdOeN;
  logic backupActive, outputFromBackup, chipEnableOutN;
  int miscompares = 0;
  int nChecks = 0;
  int n;

  always #12.5 clk = ~clk;

  supply_supervisor_reset_gating #(.HOLD_CYCLES(HOLD), .WD_CYCLES(WDC)) i_dut (
    .clk(clk), .rst_n(rst_n), .supplyLow(supplyLow),
    .manualResetN(manualResetN), .auxUndervoltageN(auxUndervoltageN),
    .watchdogActivityIn(activity), .watchdogConnected(watchdogConnected),
    .backupAbove(backupAbove), .supplyAbove(supplyAbove),
    .chipEnableInN(ceInN), .resetN(resetN), .resetOdOut(resetOdOut),
    .resetLowOdOeN(resetLowOdOeN), .resetHighOdOeN(resetHighOdOeN),
    .backupActive(backupActive), .outputFromBackup(outputFromBackup),
    .chipEnableOutN(chipEnableOutN));

  processor_model #(.KICK_CYCLES(10)) i_cpu (
    .clk(clk), .kickOn(kickOn), .ceLowReq(ceLowReq),
    .watchdogActivityIn(activity), .chipEnableInN(ceInN));

  // ----------------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic wait_reset(logic lvl, int lim, output int cnt);
    cnt = 0;
    while (resetN !== lvl && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
  endtask

  function automatic logic inr(int v, int lo, int hi);
    return (v >= lo && v <= hi) ? 1'h1 : 1'h0;
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic test_power_up();
    check("resetN in reset", resetN, 1'h0);
    check("low od oe in reset", resetLowOdOeN, 1'h0);
    check("high od oe in reset", resetHighOdOeN, 1'h1);
    check("ce out in reset", chipEnableOutN, 1'h1);
    rst_n = 1'h1;
    wait_reset(1'h1, HOLD + 20, n);
    check("power-up hold", inr(n, HOLD, HOLD + 5), 1'h1);
    check("low od oe idle", resetLowOdOeN, 1'h1);
    check("high od oe idle", resetHighOdOeN, 1'h0);
    check("od data", resetOdOut, 1'h0);
    $display("test power_up done");
  endtask

  task automatic test_causes();
    for (int i = 0; i < 3; i++) begin
      supplyLow = (i == 0);
      manualResetN = (i != 1);
      auxUndervoltageN = (i != 2);
      cyc(4);
      check("reset on cause", resetN, 1'h0);
      cyc(HOLD + 10);
      check("reset held by cause", resetN, 1'h0);
      supplyLow = 1'h0;
      manualResetN = 1'h1;
      auxUndervoltageN = 1'h1;
      wait_reset(1'h1, HOLD + 20, n);
      check("hold after cause", inr(n, HOLD, HOLD + 5), 1'h1);
    end
    $display("test causes done");
  endtask

  task automatic test_watchdog();
    watchdogConnected = 1'h1;
    kickOn = 1'h1;
    cyc(3 * WDC);
    check("serviced watchdog", resetN, 1'h1);
    kickOn = 1'h0;
    wait_reset(1'h0, WDC + 30, n);
    check("timeout", inr(n, WDC - 12, WDC + 6), 1'h1);
    wait_reset(1'h1, HOLD + 10, n);
    check("pulse length", inr(n, HOLD - 1, HOLD + 3), 1'h1);
    wait_reset(1'h0, WDC + 30, n);
    check("repeat timeout", inr(n, WDC - 2, WDC + 8), 1'h1);
    wait_reset(1'h1, HOLD + 10, n);
    kickOn = 1'h1;
    cyc(3 * WDC);
    check("kick after pulse", resetN, 1'h1);
    watchdogConnected = 1'h0;
    kickOn = 1'h0;
    cyc(3 * WDC);
    check("watchdog disabled", resetN, 1'h1);
    $display("test watchdog done");
  endtask

  task automatic test_ce_gating();
    ceLowReq = 1'h1;
    cyc(4);
    check("ce pass low", chipEnableOutN, 1'h0);
    manualResetN = 1'h0;
    cyc(100);
    check("ce grace low", chipEnableOutN, 1'h0);
    cyc(GRACE);
    check("ce after grace", chipEnableOutN, 1'h1);
    ceLowReq = 1'h0;
    cyc(5);
    ceLowReq = 1'h1;
    cyc(5);
    check("ce ignores input", chipEnableOutN, 1'h1);
    manualResetN = 1'h1;
    wait_reset(1'h1, HOLD + 20, n);
    cyc(4);
    check("ce pass again", chipEnableOutN, 1'h0);
    manualResetN = 1'h0;
    cyc(50);
    check("ce early grace", chipEnableOutN, 1'h0);
    ceLowReq = 1'h0;
    cyc(5);
    check("ce early end", chipEnableOutN, 1'h1);
    ceLowReq = 1'h1;
    cyc(5);
    check("ce stays high", chipEnableOutN, 1'h1);
    manualResetN = 1'h1;
    wait_reset(1'h1, HOLD + 20, n);
    ceLowReq = 1'h0;
    cyc(4);
    manualResetN = 1'h0;
    cyc(10);
    ceLowReq = 1'h1;
    cyc(10);
    check("ce high at start", chipEnableOutN, 1'h1);
    manualResetN = 1'h1;
    wait_reset(1'h1, HOLD + 20, n);
    ceLowReq = 1'h0;
    $display("test ce_gating done");
  endtask

  task automatic test_backup();
    supplyLow = 1'h1;
    cyc(5);
    check("no margin", backupActive, 1'h0);
    backupAbove = 1'h1;
    cyc(5);
    check("backup on", backupActive, 1'h1);
    check("out from battery", outputFromBackup, 1'h1);
    backupAbove = 1'h0;
    cyc(5);
    check("hysteresis", backupActive, 1'h1);
    supplyAbove = 1'h1;
    cyc(5);
    check("backup left", backupActive, 1'h0);
    check("out from main", outputFromBackup, 1'h0);
    supplyAbove = 1'h0;
    backupAbove = 1'h1;
    cyc(5);
    check("backup again", backupActive, 1'h1);
    supplyLow = 1'h0;
    cyc(5);
    check("supply back", backupActive, 1'h0);
    backupAbove = 1'h0;
    wait_reset(1'h1, HOLD + 20, n);
    check("out main idle", outputFromBackup, 1'h0);
    $display("test backup done");
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    cyc(8);
    test_power_up();
    test_causes();
    test_watchdog();
    test_ce_gating();
    test_backup();
    complete_run();
  end

  initial begin
    repeat (20000) @(negedge clk);
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
